/* File: rtl/dmia_defs.vh */
// constants for the data memory indirect addressing block
`ifndef DMIA_DEFS_VH
`define DMIA_DEFS_VH

// ----------------------------------------------------------------
// register offsets in the shared special register area
// ----------------------------------------------------------------
`define DMIA_ADDR_PORT_A   8'h00
`define DMIA_ADDR_PTR_A    8'h01
`define DMIA_ADDR_PORT_B   8'h02
`define DMIA_ADDR_PTR_B    8'h03
`define DMIA_ADDR_BANK_SEL 8'h04
`define DMIA_ADDR_ALU_HOLD 8'h05

// ----------------------------------------------------------------
// memory layout
// ----------------------------------------------------------------
`define DMIA_GP_BASE       8'h80
`define DMIA_BANK_ZERO     3'h0
`define DMIA_RAM_DEPTH     1024
`define DMIA_RAM_AW        10
`define DMIA_READ_ZERO     8'h00

// ----------------------------------------------------------------
// bank select fields and reset values
// ----------------------------------------------------------------
`define DMIA_DBANK_LSB     0
`define DMIA_DBANK_MSB     2
`define DMIA_PBANK_LSB     5
`define DMIA_PBANK_MSB     6
`define DMIA_BANK_WMASK    8'h67
`define DMIA_BANK_RST      8'h00
`define DMIA_PTR_RST       8'h00
`define DMIA_ALU_RST       8'h00

`endif

/* File: rtl/dmia_addr_path.v */
// address formation for direct and indirect data memory accesses
`timescale 1ns/1ps
`include "dmia_defs.vh"

module dmia_addr_path (
  input  wire [7:0]                 i_addr,
  input  wire [7:0]                 i_ptr_a,
  input  wire [7:0]                 i_ptr_b,
  input  wire [2:0]                 i_dbank,
  output reg  [7:0]                 o_low,
  output reg  [2:0]                 o_bank,
  output reg                        o_ind,
  output reg                        o_null,
  output reg                        o_gp,
  output reg  [`DMIA_RAM_AW-1:0]    o_ram_addr
);

  // ----------------------------------------------------------------
  // port decode and pointer pairing
  // ----------------------------------------------------------------
  // both ports are address aliases only, never storage
  always @* begin
    o_ind  = 1'b0;
    o_low  = i_addr;
    o_bank = `DMIA_BANK_ZERO;
    if (i_addr == `DMIA_ADDR_PORT_A) begin
      o_ind  = 1'b1;
      o_low  = i_ptr_a;
      o_bank = `DMIA_BANK_ZERO;
    end else if (i_addr == `DMIA_ADDR_PORT_B) begin
      o_ind  = 1'b1;
      o_low  = i_ptr_b;
      o_bank = i_dbank;
    end
    // a pointer aimed at a port reads zero and writes nothing
    o_null = o_ind && ((o_low == `DMIA_ADDR_PORT_A) ||
                       (o_low == `DMIA_ADDR_PORT_B));
    // below the general area the bank is ignored: shared registers
    o_gp       = (o_low >= `DMIA_GP_BASE);
    o_ram_addr = {o_bank, o_low[6:0]};
  end

endmodule

/* File: rtl/dmia_gp_ram.v */
// general purpose data memory, eight banks of 128 bytes
`timescale 1ns/1ps
`include "dmia_defs.vh"

module dmia_gp_ram (
  input  wire                       i_clk_sys,
  input  wire                       i_ce,
  input  wire                       i_we,
  input  wire [`DMIA_RAM_AW-1:0]    i_addr,
  input  wire [7:0]                 i_wdata,
  output wire [7:0]                 o_rdata
);

  reg [7:0] mem [0:`DMIA_RAM_DEPTH-1];

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // volatile contents, so no reset; the read is combinational so the
  // caller can register the answer in a single cycle
  always @(posedge i_clk_sys) begin
    if (i_ce && i_we) begin
      mem[i_addr] <= i_wdata;
    end
  end

  assign o_rdata = mem[i_addr];

endmodule

/* File: rtl/dmia_core.v */
// data memory address path: shared registers, pointers, bank select and accumulator
`timescale 1ns/1ps
`include "dmia_defs.vh"

module dmia_core (
  input  wire                       i_clk_sys,
  input  wire                       i_nrst,
  input  wire                       i_ce,
  input  wire                       i_req,
  input  wire                       i_wr,
  input  wire [7:0]                 i_addr,
  input  wire [7:0]                 i_wdata,
  input  wire                       i_alu_ld,
  input  wire [7:0]                 i_alu_res,
  input  wire                       i_sys_rst,
  input  wire                       i_wdt_idle_rst,
  output reg  [7:0]                 o_rdata,
  output reg                        o_rvalid,
  output reg                        o_null_hit,
  output reg  [7:0]                 o_alu_hold,
  output reg  [7:0]                 o_ptr_a,
  output reg  [7:0]                 o_ptr_b,
  output reg  [2:0]                 o_data_bank,
  output reg  [1:0]                 o_prog_bank
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  reg  [7:0]                pointer_a_r;
  reg  [7:0]                pointer_b_r;
  reg  [7:0]                bank_select_r;
  reg  [7:0]                alu_hold_r;

  reg  [7:0]                pointer_a_nxt;
  reg  [7:0]                pointer_b_nxt;
  reg  [7:0]                bank_select_nxt;
  reg  [7:0]                alu_hold_nxt;
  reg  [7:0]                rdata_nxt;

  // ----------------------------------------------------------------
  // address path outputs
  // ----------------------------------------------------------------
  wire [7:0]                eff_low;
  wire [2:0]                eff_bank;
  wire                      eff_ind;
  wire                      eff_null;
  wire                      eff_gp;
  wire [`DMIA_RAM_AW-1:0]   ram_addr;
  wire [7:0]                ram_rdata;
  wire [2:0]                data_bank_field;

  wire                      do_read;
  wire                      do_write;
  wire                      ram_we;
  wire                      sfr_we;
  wire                      wr_ptr_a;
  wire                      wr_ptr_b;
  wire                      wr_bank;
  wire                      wr_acc;

  assign data_bank_field = bank_select_r[`DMIA_DBANK_MSB:`DMIA_DBANK_LSB];

  // ----------------------------------------------------------------
  // address formation
  // ----------------------------------------------------------------
  // one shared path for direct and indirect requests keeps the
  // pointer pairing and bank reach in a single place
  dmia_addr_path u_addr_path (
    .i_addr     (i_addr),
    .i_ptr_a    (pointer_a_r),
    .i_ptr_b    (pointer_b_r),
    .i_dbank    (data_bank_field),
    .o_low      (eff_low),
    .o_bank     (eff_bank),
    .o_ind      (eff_ind),
    .o_null     (eff_null),
    .o_gp       (eff_gp),
    .o_ram_addr (ram_addr)
  );

  // ----------------------------------------------------------------
  // request qualification
  // ----------------------------------------------------------------
  // a write through a pointer aimed at a port is dropped whole
  assign do_read  = i_req && !i_wr;
  assign do_write = i_req && i_wr && !eff_null;
  assign ram_we   = do_write && eff_gp;
  assign sfr_we   = do_write && !eff_gp;

  // ----------------------------------------------------------------
  // general purpose memory
  // ----------------------------------------------------------------
  dmia_gp_ram u_gp_ram (
    .i_clk_sys  (i_clk_sys),
    .i_ce       (i_ce),
    .i_we       (ram_we),
    .i_addr     (ram_addr),
    .i_wdata    (i_wdata),
    .o_rdata    (ram_rdata)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // unmapped shared locations answer zero rather than stale data,
  // so software probing holes sees a stable value
  always @* begin
    rdata_nxt = `DMIA_READ_ZERO;
    if (eff_null) begin
      rdata_nxt = `DMIA_READ_ZERO;
    end else if (eff_gp) begin
      rdata_nxt = ram_rdata;
    end else begin
      case (eff_low)
        `DMIA_ADDR_PTR_A: begin
          rdata_nxt = pointer_a_r;
        end
        `DMIA_ADDR_PTR_B: begin
          rdata_nxt = pointer_b_r;
        end
        `DMIA_ADDR_BANK_SEL: begin
          rdata_nxt = bank_select_r & `DMIA_BANK_WMASK;
        end
        `DMIA_ADDR_ALU_HOLD: begin
          rdata_nxt = alu_hold_r;
        end
        default: begin
          rdata_nxt = `DMIA_READ_ZERO;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register write decode
  // ----------------------------------------------------------------
  // one strobe per register; a dropped null write never reaches any
  // of them, and holes in the shared area simply match no strobe
  assign wr_ptr_a = sfr_we && (eff_low == `DMIA_ADDR_PTR_A);
  assign wr_ptr_b = sfr_we && (eff_low == `DMIA_ADDR_PTR_B);
  assign wr_bank  = sfr_we && (eff_low == `DMIA_ADDR_BANK_SEL);
  assign wr_acc   = sfr_we && (eff_low == `DMIA_ADDR_ALU_HOLD);

  // ----------------------------------------------------------------
  // next register values
  // ----------------------------------------------------------------
  // write data comes from the core's data bus, and for the accumulator also
  // from the ALU result; there is
  // no path from one register's output to another's input here
  always @* begin
    pointer_a_nxt = pointer_a_r;
    if (wr_ptr_a) begin
      pointer_a_nxt = i_wdata;
    end
  end

  // second pointer, same treatment as the first
  always @* begin
    pointer_b_nxt = pointer_b_r;
    if (wr_ptr_b) begin
      pointer_b_nxt = i_wdata;
    end
  end

  // unimplemented bank select bits are never stored, so they read 0;
  // core reset returns the selection to zero unless it is the
  // watchdog wake from idle, which must resume in the same bank
  always @* begin
    bank_select_nxt = bank_select_r;
    if (wr_bank) begin
      bank_select_nxt = i_wdata & `DMIA_BANK_WMASK;
    end
    if (i_sys_rst && !i_wdt_idle_rst) begin
      bank_select_nxt = `DMIA_BANK_RST;
    end
  end

  // an ALU result overrides a bus write to the accumulator in the
  // same cycle, since the ALU write-back is the later pipeline stage
  always @* begin
    alu_hold_nxt = alu_hold_r;
    if (wr_acc) begin
      alu_hold_nxt = i_wdata;
    end
    if (i_alu_ld) begin
      alu_hold_nxt = i_alu_res;
    end
  end

  // ----------------------------------------------------------------
  // register update
  // ----------------------------------------------------------------
  // first pointer; a low clock enable freezes every register below
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      pointer_a_r <= `DMIA_PTR_RST;
    end else if (i_ce) begin
      pointer_a_r <= pointer_a_nxt;
    end
  end

  // second pointer
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      pointer_b_r <= `DMIA_PTR_RST;
    end else if (i_ce) begin
      pointer_b_r <= pointer_b_nxt;
    end
  end

  // bank selection; power-on reset always starts in bank zero, the
  // idle watchdog exception lives in the synchronous path above
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      bank_select_r <= `DMIA_BANK_RST;
    end else if (i_ce) begin
      bank_select_r <= bank_select_nxt;
    end
  end

  // accumulator; not cleared by the core reset pulse, only by power-on
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      alu_hold_r <= `DMIA_ALU_RST;
    end else if (i_ce) begin
      alu_hold_r <= alu_hold_nxt;
    end
  end

  // ----------------------------------------------------------------
  // read answer and status outputs
  // ----------------------------------------------------------------
  // all outputs come straight from flip-flops so they are glitch free;
  // the status pulses stand for one enabled cycle only
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rvalid   <= 1'b0;
      o_null_hit <= 1'b0;
    end else if (i_ce) begin
      o_rvalid   <= do_read;
      o_null_hit <= i_req && eff_null;
    end
  end

  // read data holds the last answer until the next read is taken
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= `DMIA_READ_ZERO;
    end else if (i_ce && do_read) begin
      o_rdata <= rdata_nxt;
    end
  end

  // accumulator mirror, loaded from the next value at the same edge
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_alu_hold <= `DMIA_ALU_RST;
    end else if (i_ce) begin
      o_alu_hold <= alu_hold_nxt;
    end
  end

  // pointer mirrors take the next values, so they never lag the
  // registers themselves; this costs a wider fan-in but no latency
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ptr_a <= `DMIA_PTR_RST;
      o_ptr_b <= `DMIA_PTR_RST;
    end else if (i_ce) begin
      o_ptr_a <= pointer_a_nxt;
      o_ptr_b <= pointer_b_nxt;
    end
  end

  // bank field mirrors for the data and program bank selections
  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_data_bank <= 3'h0;
      o_prog_bank <= 2'h0;
    end else if (i_ce) begin
      o_data_bank <= bank_select_nxt[`DMIA_DBANK_MSB:`DMIA_DBANK_LSB];
      o_prog_bank <= bank_select_nxt[`DMIA_PBANK_MSB:`DMIA_PBANK_LSB];
    end
  end

endmodule

/* File: test/dmia_core_checker.sv */
// assertion checker watching the ports of the data memory core
`timescale 1ns/1ps
module dmia_core_checker (
  input wire       i_clk_sys,
  input wire       i_nrst,
  input wire       i_ce,
  input wire       i_req,
  input wire       i_wr,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire       i_alu_ld,
  input wire [7:0] i_alu_res,
  input wire       i_sys_rst,
  input wire       i_wdt_idle_rst,
  input wire [7:0] o_rdata,
  input wire       o_null_hit,
  input wire [7:0] o_alu_hold,
  input wire [7:0] o_ptr_a,
  input wire [7:0] o_ptr_b,
  input wire [2:0] o_data_bank
);
  // ----------------
  // access decode
  // ----------------
  default clocking dmia_cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  // accesses taken at this edge
  wire rd = i_ce & i_req & ~i_wr;
  wire wt = i_ce & i_req & i_wr;
  // ----------------
  // properties
  // ----------------
  a_reserved_read_zero: assert property (
    rd && i_addr > 8'h05 && i_addr < 8'h80 |=> o_rdata == 8'h00) else $error("hole not zero");
  a_ptr_a_write: assert property (
    wt && i_addr == 8'h01 |=> o_ptr_a == $past(i_wdata)) else $error("pointer a lost write");
  a_null_read_zero: assert property (
    rd && i_addr == 8'h00 && o_ptr_a[7:2] == 6'h00 && !o_ptr_a[0]
    |=> o_null_hit && o_rdata == 8'h00) else $error("null read not zero");
  a_null_write_inert: assert property (
    wt && i_addr == 8'h02 && o_ptr_b[7:2] == 6'h00 && !o_ptr_b[0] && !i_alu_ld
    |=> $stable(o_ptr_b) && $stable(o_alu_hold)) else $error("null write changed state");
  a_port_reaches_target: assert property (
    wt && i_addr == 8'h00 && o_ptr_a == 8'h05 && !i_alu_ld
    |=> o_alu_hold == $past(i_wdata)) else $error("port a missed target");
  a_alu_load: assert property (
    i_ce && i_alu_ld |=> o_alu_hold == $past(i_alu_res)) else $error("alu result lost");
  a_bank_clear: assert property (
    i_ce && i_sys_rst && !i_wdt_idle_rst && !i_req |=> o_data_bank == 3'h0)
    else $error("bank not cleared");
  a_bank_kept: assert property (
    i_ce && i_sys_rst && i_wdt_idle_rst && !i_req |=> $stable(o_data_bank))
    else $error("bank lost on idle reset");
  c_null_read: cover property (rd && i_addr == 8'h00 && o_ptr_a == 8'h00);
  c_bank_kept: cover property (i_ce && i_sys_rst && i_wdt_idle_rst);
  c_port_acc: cover property (wt && i_addr == 8'h00 && o_ptr_a == 8'h05);
endmodule

bind dmia_core dmia_core_checker dmia_core_checker_inst (
  .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ce(i_ce), .i_req(i_req), .i_wr(i_wr),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_alu_ld(i_alu_ld), .i_alu_res(i_alu_res),
  .i_sys_rst(i_sys_rst), .i_wdt_idle_rst(i_wdt_idle_rst), .o_rdata(o_rdata),
  .o_null_hit(o_null_hit), .o_alu_hold(o_alu_hold), .o_ptr_a(o_ptr_a),
  .o_ptr_b(o_ptr_b), .o_data_bank(o_data_bank));

/* File: test/dmia_exec_model.sv */
// model of the instruction execution core issuing data memory steps
`timescale 1ns/1ps
module dmia_exec_model (
  input  wire       i_clk_sys,
  output reg        o_ce,
  output reg        o_req,
  output reg        o_wr,
  output reg  [7:0] o_addr,
  output reg  [7:0] o_wdata,
  output reg        o_alu_ld,
  output reg  [7:0] o_alu_res,
  output reg        o_sys_rst,
  output reg        o_wdt_idle_rst
);
  // ----------------
  // instruction step
  // ----------------
  // idle core at time zero
  initial begin
    {o_ce, o_req, o_wr, o_addr, o_wdata, o_alu_ld, o_alu_res, o_sys_rst, o_wdt_idle_rst} = 0;
  end
  // fields change at the falling edge only, so they stand across the sampling edge
  task cyc(input logic [5:0] c, input logic [7:0] a, input logic [7:0] d, input logic [7:0] r);
    @(negedge i_clk_sys);
    {o_ce, o_req, o_wr, o_alu_ld, o_sys_rst, o_wdt_idle_rst} = c;
    o_addr = a;
    o_wdata = d;
    o_alu_res = r;
    @(posedge i_clk_sys);
    #1;
  endtask
endmodule

/* File: test/data_memory_indirect_addressing_bench.sv */
// self-checking bench for the data memory core
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module data_memory_indirect_addressing_bench;
  logic       i_clk_sys = 0;
  logic       i_nrst = 0;
  wire        i_ce, i_req, i_wr, i_alu_ld, i_sys_rst, i_wdt_idle_rst, o_rvalid, o_null_hit;
  wire  [7:0] i_addr, i_wdata, i_alu_res, o_rdata, o_alu_hold, o_ptr_a, o_ptr_b;
  wire  [2:0] o_data_bank;
  wire  [1:0] o_prog_bank;
  int         mismatches, total_checks, cycles, pa, pb, bs, acc;
  int         ram [0:1151];
  logic [5:0] c;
  // ----------------
  // clock, parts, watchdog
  // ----------------
  always #5 i_clk_sys = ~i_clk_sys;
  dmia_exec_model dmia_exec_model_inst (.i_clk_sys(i_clk_sys), .o_ce(i_ce), .o_req(i_req),
    .o_wr(i_wr), .o_addr(i_addr), .o_wdata(i_wdata), .o_alu_ld(i_alu_ld),
    .o_alu_res(i_alu_res), .o_sys_rst(i_sys_rst), .o_wdt_idle_rst(i_wdt_idle_rst));
  dmia_core dmia_core_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ce(i_ce),
    .i_req(i_req), .i_wr(i_wr), .i_addr(i_addr), .i_wdata(i_wdata), .i_alu_ld(i_alu_ld),
    .i_alu_res(i_alu_res), .i_sys_rst(i_sys_rst), .i_wdt_idle_rst(i_wdt_idle_rst),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_null_hit(o_null_hit), .o_alu_hold(o_alu_hold),
    .o_ptr_a(o_ptr_a), .o_ptr_b(o_ptr_b), .o_data_bank(o_data_bank), .o_prog_bank(o_prog_bank));
  // a hang counts as a mismatch
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test;
    end
  end
  // ----------------
  // reference model
  // ----------------
  // port a and direct stay in bank zero, port b follows the data bank field
  function automatic int tgt(int a);
    int t;
    t = (a == 0) ? pa : (a == 2) ? pb : a;
    if (t < 128 || a != 2) return t;
    return (bs & 7) * 128 + t;
  endfunction
  function automatic int mread(int a);
    int t;
    t = tgt(a);
    if (t >= 128) return ram[t];
    return (t == 1) ? pa : (t == 3) ? pb : (t == 4) ? bs : (t == 5) ? acc : 0;
  endfunction
  // one step on both sides, then the mirrors compared, and the read and null outputs on enabled steps
  task op(input logic [5:0] k, input int a, input int d, input int r);
    int e, t, nul;
    e = mread(a);
    t = tgt(a);
    nul = (a == 0 || a == 2) && (t == 0 || t == 2);
    dmia_exec_model_inst.cyc(k, a[7:0], d[7:0], r[7:0]);
    if (k[5]) begin
      `CHK("rvalid", k[4] && !k[3], o_rvalid)
      if (k[4] && !k[3]) `CHK("rdata", e, o_rdata)
      `CHK("null_hit", k[4] && nul, o_null_hit)
      if (k[4] && k[3]) begin
        case (t)
          1: pa = d;
          3: pb = d;
          4: bs = d & 8'h67;
          5: acc = d;
          default: if (t >= 128) ram[t] = d;
        endcase
      end
      if (k[2]) acc = r;
      if (k[1] && !k[0]) bs = 0;
    end
    `CHK("ptr_a", pa, o_ptr_a)
    `CHK("ptr_b", pb, o_ptr_b)
    `CHK("alu", acc, o_alu_hold)
    `CHK("dbank", bs & 7, o_data_bank)
    `CHK("pbank", bs >> 5, o_prog_bank)
  endtask
  // storage keeps its contents, registers return to zero
  task do_reset;
    op(6'h00, 0, 0, 0);
    i_nrst = 0;
    repeat (10) @(negedge i_clk_sys);
    i_nrst = 1;
    {pa, pb, bs, acc} = 0;
  endtask
  task finish_test;
    if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------
  // main sequence
  // ----------------
  initial begin
    void'($urandom(32'h73AC0DD7));
    do_reset;
    // fill every bank through the second port and pointer
    for (int b = 0; b < 8; b++) begin
      op(6'h38, 4, b, 0);
      for (int i = 0; i < 128; i++) begin
        op(6'h38, 3, 128 + i, 0);
        op(6'h38, 2, $urandom % 256, 0);
      end
    end
    // memory to memory copy, 0x81 to 0x90, passes through the accumulator
    op(6'h24, 0, 0, mread(8'h81));
    op(6'h38, 8'h90, acc, 0);
    op(6'h30, 8'h90, 0, 0);
    // random steps, pointers biased to the port and register addresses
    for (int n = 0; n < 1500; n++) begin
      c = $urandom;
      if (c[4]) c[1] = 0;
      op(c, ($urandom % 3 == 0) ? $urandom % 6 : $urandom % 256,
         ($urandom % 2) ? $urandom % 6 : $urandom % 256, $urandom % 256);
    end
    do_reset;
    for (int a = 1; a < 6; a++) op(6'h30, a, 0, 0);
    finish_test;
  end
endmodule
